// ### core/cs_accum.sv
`timescale 1ns/1ps
`default_nettype none
module cs_accum
  import cs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  cs_conv_if.acc bus
);
  typedef enum logic {CS_ACC_IDLE, CS_ACC_WAIT} cs_acc_state_type;

  cs_acc_state_type state, next_state;
  logic [CS_COUNT_WIDTH-1:0] count, next_count;
  logic [CS_ACC_WIDTH-1:0] acc, next_acc;
  logic [CS_RESULT_WIDTH-1:0] result, next_result;
  logic conv_start, next_conv_start;
  logic set_done, next_set_done;
  logic gt_event, next_gt_event;
  logic busy, next_busy;
  logic [CS_ACC_WIDTH-1:0] sum;
  logic [CS_ACC_WIDTH-1:0] divided;
  logic [CS_COUNT_WIDTH-1:0] total;
  logic [2:0] shift;

  always_comb
  begin
    shift = cs_acc_shift(bus.acc_sel);
    total = CS_COUNT_WIDTH'(1) << shift;
    sum = acc + CS_ACC_WIDTH'(bus.sample_data);
    divided = sum >> shift;
    next_state = state;
    next_count = count;
    next_acc = acc;
    next_result = result;
    next_conv_start = 1'b0;
    next_set_done = 1'b0;
    next_gt_event = 1'b0;
    if (bus.abort)
    begin
      next_state = CS_ACC_IDLE;
      next_acc = '0;
      next_count = '0;
    end
    else
    begin
      unique case (state)
        CS_ACC_IDLE:
        begin
          if (bus.set_start)
          begin
            next_acc = '0;
            next_count = '0;
            next_conv_start = 1'b1;
            next_state = CS_ACC_WAIT;
          end
        end
        CS_ACC_WAIT:
        begin
          if (bus.sample_valid)
          begin
            if (count + CS_COUNT_WIDTH'(1) == total)
            begin
              next_result = divided[CS_RESULT_WIDTH-1:0];
              next_set_done = 1'b1;
              // compare only once the whole set is summed
              next_gt_event = bus.cmp_en &&
                (divided[CS_RESULT_WIDTH-1:0] > bus.threshold);
              next_state = CS_ACC_IDLE;
            end
            else
            begin
              next_acc = sum;
              next_count = count + CS_COUNT_WIDTH'(1);
              next_conv_start = 1'b1;
            end
          end
        end
      endcase
    end
    next_busy = (next_state == CS_ACC_WAIT);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state <= CS_ACC_IDLE;
      count <= '0;
      acc <= '0;
      result <= '0;
      conv_start <= 1'b0;
      set_done <= 1'b0;
      gt_event <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      acc <= next_acc;
      result <= next_result;
      conv_start <= next_conv_start;
      set_done <= next_set_done;
      gt_event <= next_gt_event;
      busy <= next_busy;
    end
  end

  assign bus.busy = busy;
  assign bus.set_done = set_done;
  assign bus.gt_event = gt_event;
  assign bus.conv_start = conv_start;
  assign bus.result = result;
endmodule
`default_nettype wire

// ### core/cs_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cs_conv_if;
  logic set_start;
  logic abort;
  logic busy;
  logic set_done;
  logic gt_event;
  logic conv_start;
  logic [15:0] result;
  logic [2:0] acc_sel;
  logic cmp_en;
  logic [15:0] threshold;
  logic sample_valid;
  logic [15:0] sample_data;
  modport trig (output set_start, output abort, input busy, input set_done,
    input gt_event, input acc_sel);
  modport acc (input set_start, input abort, input acc_sel, input cmp_en,
    input threshold, input sample_valid, input sample_data, output busy,
    output set_done, output gt_event, output conv_start, output result);
  modport ctl (output acc_sel, output cmp_en, output threshold, output sample_valid,
    output sample_data, input busy, input set_done, input gt_event, input conv_start,
    input result);
endinterface
`default_nettype wire

// ### core/cs_pkg.sv
package cs_pkg;
  localparam logic [7:0] CS_ADDR_CONFIG = 8'h9e;
  localparam logic [7:0] CS_ADDR_RESULT_HIGH = 8'hac;
  localparam logic [7:0] CS_ADDR_CONTROL = 8'hb0;
  localparam logic [7:0] CS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CS_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CS_RESULT_RESET = 8'h00;
  localparam int CS_CTL_ENABLE_BIT = 7;
  localparam int CS_CTL_DONE_BIT = 5;
  localparam int CS_CTL_BUSY_BIT = 4;
  localparam int CS_CTL_CMPEN_BIT = 3;
  localparam int CS_CTL_GT_BIT = 0;
  localparam int CS_CFG_SRC_LSB = 4;
  localparam int CS_CFG_ACC_LSB = 0;
  localparam int CS_FIELD_WIDTH = 3;
  localparam logic [2:0] CS_SRC_MANUAL = 3'h0;
  localparam logic [2:0] CS_SRC_TIMER0 = 3'h1;
  localparam logic [2:0] CS_SRC_TIMER2 = 3'h2;
  localparam logic [2:0] CS_SRC_TIMER1 = 3'h3;
  localparam logic [2:0] CS_SRC_CONTINUOUS = 3'h6;
  localparam logic [2:0] CS_SRC_AUTOSCAN = 3'h7;
  localparam logic [2:0] CS_ACC_MAX_CODE = 3'h5;
  localparam int CS_ACC_WIDTH = 22;
  localparam int CS_RESULT_WIDTH = 16;
  localparam int CS_COUNT_WIDTH = 7;
  localparam int CS_RESULT_HIGH_LSB = 8;

  // right shift that divides by the sample count: 1,4,8,16,32,64
  function automatic logic [2:0] cs_acc_shift(input logic [2:0] sel);
    logic [2:0] s;
    s = 3'h0;
    case (sel)
      3'h1: s = 3'h2;
      3'h2: s = 3'h3;
      3'h3: s = 3'h4;
      3'h4: s = 3'h5;
      3'h5: s = 3'h6;
      default: s = 3'h0;
    endcase
    return s;
  endfunction
endpackage

// ### core/cs_top.sv
`timescale 1ns/1ps
`default_nettype none
module cs_top
  import cs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_timer0_ovf,
  input wire logic i_timer1_ovf,
  input wire logic i_timer2_ovf,
  input wire logic [15:0] i_threshold,
  input wire logic i_sample_valid,
  input wire logic [15:0] i_sample_data,
  output logic o_unit_enable,
  output logic o_conv_start,
  output logic o_auto_scan,
  output logic o_scan_advance,
  output logic o_wake,
  output logic [15:0] o_result
);
  import cs_pkg::*;

  cs_conv_if conv ();

  logic unit_enable, next_unit_enable;
  logic done_flag, next_done_flag;
  logic compare_enable, next_compare_enable;
  logic gt_flag, next_gt_flag;
  logic [2:0] start_source_select, next_start_source_select;
  logic [2:0] accumulate_count_select, next_accumulate_count_select;
  logic [7:0] rdata, next_rdata;
  logic auto_scan, next_auto_scan;
  logic scan_advance, next_scan_advance;
  logic wake, next_wake;
  logic wr_control;
  logic wr_config;
  logic busy_write;
  logic [7:0] control_view;
  logic [7:0] config_view;

  assign conv.acc_sel = accumulate_count_select;
  assign conv.cmp_en = compare_enable;
  assign conv.threshold = i_threshold;
  assign conv.sample_valid = i_sample_valid;
  assign conv.sample_data = i_sample_data;

  cs_trigger u_trigger (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_enable(unit_enable),
    .i_source(start_source_select),
    .i_busy_write(busy_write),
    .i_timer0_ovf(i_timer0_ovf),
    .i_timer1_ovf(i_timer1_ovf),
    .i_timer2_ovf(i_timer2_ovf),
    .bus(conv)
  );

  cs_accum u_accum (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .bus(conv)
  );

  always_comb
  begin
    wr_control = i_sfr_wr && (i_sfr_addr == CS_ADDR_CONTROL);
    wr_config = i_sfr_wr && (i_sfr_addr == CS_ADDR_CONFIG);
    busy_write = wr_control && i_sfr_wdata[CS_CTL_BUSY_BIT];
    next_unit_enable = wr_control ? i_sfr_wdata[CS_CTL_ENABLE_BIT] : unit_enable;
    next_compare_enable = wr_control ? i_sfr_wdata[CS_CTL_CMPEN_BIT] : compare_enable;
    // hardware set beats a same-cycle software clear
    next_done_flag = conv.set_done ||
      (wr_control ? i_sfr_wdata[CS_CTL_DONE_BIT] : done_flag);
    next_gt_flag = conv.gt_event ||
      (gt_flag && !(wr_control && !i_sfr_wdata[CS_CTL_GT_BIT]));
    next_start_source_select = wr_config ?
      i_sfr_wdata[CS_CFG_SRC_LSB +: CS_FIELD_WIDTH] : start_source_select;
    next_accumulate_count_select = wr_config ?
      i_sfr_wdata[CS_CFG_ACC_LSB +: CS_FIELD_WIDTH] : accumulate_count_select;
    control_view = 8'h00;
    control_view[CS_CTL_ENABLE_BIT] = unit_enable;
    control_view[CS_CTL_DONE_BIT] = done_flag;
    control_view[CS_CTL_BUSY_BIT] = conv.busy;
    control_view[CS_CTL_CMPEN_BIT] = compare_enable;
    control_view[CS_CTL_GT_BIT] = gt_flag;
    config_view = 8'h00;
    config_view[CS_CFG_SRC_LSB +: CS_FIELD_WIDTH] = start_source_select;
    config_view[CS_CFG_ACC_LSB +: CS_FIELD_WIDTH] = accumulate_count_select;
    next_rdata = rdata;
    if (i_sfr_rd)
    begin
      unique case (i_sfr_addr)
        CS_ADDR_CONTROL: next_rdata = control_view;
        CS_ADDR_CONFIG: next_rdata = config_view;
        CS_ADDR_RESULT_HIGH: next_rdata = conv.result[CS_RESULT_HIGH_LSB +: 8];
        default: next_rdata = 8'h00;
      endcase
    end
    next_auto_scan = unit_enable && (start_source_select == CS_SRC_AUTOSCAN);
    // mux stays on the channel that tripped the threshold
    next_scan_advance = auto_scan && conv.set_done && !conv.gt_event;
    // a two-clock quiet time after wake is left to firmware
    next_wake = conv.gt_event;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      unit_enable <= CS_CONTROL_RESET[CS_CTL_ENABLE_BIT];
      done_flag <= CS_CONTROL_RESET[CS_CTL_DONE_BIT];
      compare_enable <= CS_CONTROL_RESET[CS_CTL_CMPEN_BIT];
      gt_flag <= CS_CONTROL_RESET[CS_CTL_GT_BIT];
      start_source_select <= CS_CONFIG_RESET[CS_CFG_SRC_LSB +: CS_FIELD_WIDTH];
      accumulate_count_select <= CS_CONFIG_RESET[CS_CFG_ACC_LSB +: CS_FIELD_WIDTH];
      rdata <= CS_RESULT_RESET;
      auto_scan <= 1'b0;
      scan_advance <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      unit_enable <= next_unit_enable;
      done_flag <= next_done_flag;
      compare_enable <= next_compare_enable;
      gt_flag <= next_gt_flag;
      start_source_select <= next_start_source_select;
      accumulate_count_select <= next_accumulate_count_select;
      rdata <= next_rdata;
      auto_scan <= next_auto_scan;
      scan_advance <= next_scan_advance;
      wake <= next_wake;
    end
  end

  assign o_sfr_rdata = rdata;
  assign o_unit_enable = unit_enable;
  assign o_conv_start = conv.conv_start;
  assign o_auto_scan = auto_scan;
  assign o_scan_advance = scan_advance;
  assign o_wake = wake;
  assign o_result = conv.result;
endmodule
`default_nettype wire

// ### core/cs_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module cs_trigger
  import cs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [2:0] i_source,
  input wire logic i_busy_write,
  input wire logic i_timer0_ovf,
  input wire logic i_timer1_ovf,
  input wire logic i_timer2_ovf,
  cs_conv_if.trig bus
);
  logic armed, next_armed;
  logic set_start, next_set_start;
  logic abort, next_abort;
  logic want;
  logic continuous;

  always_comb
  begin
    continuous = (i_source == CS_SRC_CONTINUOUS) || (i_source == CS_SRC_AUTOSCAN);
    next_armed = armed;
    if (!i_enable || !continuous)
      next_armed = 1'b0;
    else if (i_busy_write)
      next_armed = 1'b1;
    else if (i_source == CS_SRC_AUTOSCAN && bus.set_done && bus.gt_event)
      next_armed = 1'b0;
    want = 1'b0;
    unique case (i_source)
      CS_SRC_MANUAL: want = i_busy_write;
      CS_SRC_TIMER0: want = i_timer0_ovf;
      CS_SRC_TIMER2: want = i_timer2_ovf;
      CS_SRC_TIMER1: want = i_timer1_ovf;
      CS_SRC_CONTINUOUS: want = next_armed;
      CS_SRC_AUTOSCAN: want = next_armed;
      default: want = 1'b0;
    endcase
    // busy rises one cycle after the start pulse, so block a double start
    next_set_start = want && i_enable && !bus.busy && !set_start &&
      (bus.acc_sel <= CS_ACC_MAX_CODE);
    next_abort = !i_enable;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      armed <= 1'b0;
      set_start <= 1'b0;
      abort <= 1'b1;
    end
    else
    begin
      armed <= next_armed;
      set_start <= next_set_start;
      abort <= next_abort;
    end
  end

  assign bus.set_start = set_start;
  assign bus.abort = abort;
endmodule
`default_nettype wire

// ### testbench/cs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cs_chk (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [15:0] i_threshold,
  input wire logic i_sample_valid,
  input wire logic o_unit_enable,
  input wire logic o_conv_start,
  input wire logic o_auto_scan,
  input wire logic o_scan_advance,
  input wire logic o_wake,
  input wire logic [15:0] o_result
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_enable;
    i_sfr_wr && i_sfr_addr == 8'hb0 |=> o_unit_enable == $past(i_sfr_wdata[7]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit lost");
  // three cycles covers a start already in the pipe
  property p_off_idle;
    !o_unit_enable [*3] |-> !o_conv_start;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("start while off");
  property p_wake;
    o_wake |-> $past(i_sample_valid, 2) && o_result > i_threshold;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_result;
    $changed(o_result) |-> $past(i_sample_valid);
  endproperty
  a_result: assert property (p_result) else $error("result moved");
  property p_high;
    i_sfr_rd && i_sfr_addr == 8'hac |=> o_sfr_rdata == $past(o_result[15:8]);
  endproperty
  a_high: assert property (p_high) else $error("high byte wrong");
  property p_ctl_pad;
    i_sfr_rd && i_sfr_addr == 8'hb0 |=> o_sfr_rdata[6] == 1'b0 && o_sfr_rdata[2:1] == 2'h0;
  endproperty
  a_ctl_pad: assert property (p_ctl_pad) else $error("control pad bits");
  property p_cfg_pad;
    i_sfr_rd && i_sfr_addr == 8'h9e |=> o_sfr_rdata[7] == 1'b0 && o_sfr_rdata[3] == 1'b0;
  endproperty
  a_cfg_pad: assert property (p_cfg_pad) else $error("config pad bits");
  property p_scan_on;
    o_auto_scan |-> $past(o_unit_enable);
  endproperty
  a_scan_on: assert property (p_scan_on) else $error("scan while off");
  property p_scan_step;
    o_scan_advance |-> $past(i_sample_valid, 2) && !o_wake;
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("bad scan step");
  c_wake: cover property (o_wake);
  c_step: cover property (o_scan_advance);
  c_scan_start: cover property (o_auto_scan && o_conv_start);
endmodule
bind cs_top cs_chk u_cs_chk (.*);
`default_nettype wire

// ### testbench/cs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cs_top_tb_top;
  import cs_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_sample_valid = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, rv;
  logic [2:0] tmr = 3'h0;
  logic [15:0] i_threshold = 16'h1000, i_sample_data = 16'h0000, o_result, exp_res;
  logic o_unit_enable, o_conv_start, o_auto_scan, o_scan_advance, o_wake;
  logic [2:0] good [3] = '{3'h1, 3'h4, 3'h2};
  logic [2:0] bad [3] = '{3'h2, 3'h1, 3'h4};
  logic [7:0] resv [3] = '{8'h40, 8'h50, 8'h06};
  int miscompares = 0;
  int checks_done = 0;
  cs_top u_cs_top (.*, .i_timer0_ovf(tmr[0]), .i_timer1_ovf(tmr[1]), .i_timer2_ovf(tmr[2]));
  initial
  begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b0;
    @(negedge i_core_clk);
    rv = o_sfr_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg_%h", a), {8'h00, rv}, {8'h00, e});
  endtask
  task automatic pulse(input logic [2:0] t);
    @(posedge i_core_clk);
    tmr <= t;
    @(posedge i_core_clk);
    tmr <= 3'h0;
  endtask
  // bounded look for a sample request; e=0 means none may come
  task automatic wait_start(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (12)
    begin
      @(negedge i_core_clk);
      seen = seen | o_conv_start;
      if (seen && e)
        break;
    end
    chk("conv_start", {15'h0, seen}, {15'h0, e});
  endtask
  task automatic run_set(input int n, input logic [15:0] b, input logic dm);
    logic [21:0] sum;
    logic [15:0] d;
    sum = 22'h0;
    for (int k = 0; k < n; k++)
    begin
      wait_start(1'b1);
      if (k == n - 1)
      begin
        rd(CS_ADDR_CONTROL);
        chk("busy_done", {14'h0, rv[5:4]}, {14'h0, dm, 1'b1});
      end
      d = b + 16'(k) * 16'h0111;
      sum = sum + 22'(d);
      @(posedge i_core_clk);
      i_sample_valid <= 1'b1;
      i_sample_data <= d;
      @(posedge i_core_clk);
      i_sample_valid <= 1'b0;
    end
    repeat (2) @(negedge i_core_clk);
    exp_res = 16'(sum >> $clog2(n));
    chk("result", o_result, exp_res);
  endtask
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    i_reset <= 1'b0;
    rc(CS_ADDR_CONTROL, 8'h00);
    rc(CS_ADDR_CONFIG, 8'h00);
    rc(CS_ADDR_RESULT_HIGH, 8'h00);
    rc(8'h55, 8'h00);
    wr(CS_ADDR_CONFIG, 8'hff);
    rc(CS_ADDR_CONFIG, 8'h77);
    wr(CS_ADDR_CONFIG, 8'h00);
    wr(CS_ADDR_CONTROL, 8'hff);
    rc(CS_ADDR_CONTROL, 8'ha8);
    wr(CS_ADDR_RESULT_HIGH, 8'hff);
    rc(CS_ADDR_RESULT_HIGH, 8'h00);
    $display("test registers done");
    wr(CS_ADDR_CONTROL, 8'h98);
    run_set(1, 16'h2345, 1'b0);
    chk("wake", {15'h0, o_wake}, 16'h0001);
    rc(CS_ADDR_RESULT_HIGH, 8'h23);
    rc(CS_ADDR_CONTROL, 8'ha9);
    repeat (20) @(posedge i_core_clk);
    rc(CS_ADDR_CONTROL, 8'ha9);
    wr(CS_ADDR_CONTROL, 8'h90);
    run_set(1, 16'h2000, 1'b0);
    rc(CS_ADDR_CONTROL, 8'ha0);
    @(posedge i_core_clk);
    // single samples cross this level, the 4-sample mean stays below
    i_threshold <= 16'hf200;
    for (int a = 1; a < 6; a++)
    begin
      wr(CS_ADDR_CONFIG, 8'(a));
      wr(CS_ADDR_CONTROL, 8'h98);
      run_set(1 << (a + 1), 16'hf000, 1'b0);
      rc(CS_ADDR_CONTROL, {7'h54, exp_res > i_threshold});
    end
    $display("test conversions done");
    wr(CS_ADDR_CONTROL, 8'h88);
    for (int s = 1; s < 4; s++)
    begin
      wr(CS_ADDR_CONFIG, 8'(s << 4));
      pulse(bad[s - 1]);
      wait_start(1'b0);
      pulse(good[s - 1]);
      run_set(1, 16'h0100, s > 1);
    end
    foreach (resv[i])
    begin
      wr(CS_ADDR_CONFIG, resv[i]);
      wr(CS_ADDR_CONTROL, 8'h98);
      wait_start(1'b0);
    end
    $display("test sources done");
    wr(CS_ADDR_CONFIG, 8'h60);
    wr(CS_ADDR_CONTROL, 8'h98);
    run_set(1, 16'h0200, 1'b0);
    run_set(1, 16'h0300, 1'b1);
    wr(CS_ADDR_CONTROL, 8'h00);
    wr(CS_ADDR_CONTROL, 8'h88);
    wait_start(1'b0);
    @(posedge i_core_clk);
    i_threshold <= 16'h1000;
    wr(CS_ADDR_CONFIG, 8'h70);
    wr(CS_ADDR_CONTROL, 8'h98);
    @(negedge i_core_clk);
    chk("auto_scan", {15'h0, o_auto_scan}, 16'h0001);
    run_set(1, 16'h0800, 1'b0);
    chk("wake_step", {14'h0, o_wake, o_scan_advance}, 16'h0001);
    run_set(1, 16'h3000, 1'b1);
    chk("wake_step", {14'h0, o_wake, o_scan_advance}, 16'h0002);
    wait_start(1'b0);
    repeat (2) @(posedge i_core_clk);
    wr(CS_ADDR_CONTROL, 8'h98);
    wait_start(1'b1);
    wr(CS_ADDR_CONTROL, 8'h00);
    $display("test modes done");
    report_and_stop();
  end
  // whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
